// File: core/trq_core.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - auto mode self-triggers; real trigger wins
// - normal mode triggers only on real events or force
// - free-run self-triggers fast, ignores real events
// - force makes one immediate acquisition
// - holdoff starts each accepted trigger, blocks next
// - no holdoff for external, serial, sequence
// - time holdoff up to 10 s, 0.0002 s steps
// - event holdoff counts events before next accept
// - random holdoff drawn fresh within min/max
// - auto holdoff is scale times horizontal scale
// - per-channel band suppresses level crossings
// - band in divisions, 0-5 div, 0.01 steps
// - band in percent, 0-50 whole steps
// - auto hysteresis picks band, readable back
// - unit choice applies only in manual mode
// - filter none, LF or HF reject; off at reset
// - LF reject passes above fixed 50 kHz
// - HF reject cutoff 1 kHz-500 MHz, default 1 MHz
module trq_core #(
   parameter int STEP_CYC = trq_pkg::STEP_CYC_DEF
) (
   // clock and reset
   input logic sys_clk,
   input logic rst_n,
   // axi4-lite write channels
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // axi4-lite read channels
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // trigger sources
   input trq_pkg::trq_smp_t chanSample,
   input logic extTrigPin,
   input logic serialTrigPin,
   // acquisition trigger
   output logic trigPulse,
   output trq_pkg::trq_kind_t trigKind,
   output logic holdoffBusy
);
   import trq_pkg::*;

   trq_ctrl_t ctrl_r;
   trq_hyst_t [NCH-1:0] hyst_r;
   logic [STEPS_W-1:0] hoTime_r, rndMin_r, rndMax_r, hScale_r;
   logic [EVT_W-1:0] hoEvents_r;
   logic [SCL_W-1:0] autoScl_r;
   logic [CUT_W-1:0] hfCut_r;
   logic forceReq_r;
   logic [31:0] trigCount_r;
   trq_state_t state_r, state_nxt;
   logic [CNT_W-1:0] hoCnt_r, hoCnt_nxt, selfCnt_r;
   logic signed [ACC_W-1:0] acc_r;
   logic signed [HW-1:0] filt_r;
   logic bandArmed_r;
   logic [1:0] pinPrev_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;

   function automatic logic [31:0] clampU(input logic [31:0] v, lo, hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clampU

   function automatic logic [CNT_W-1:0] cyc(input logic [STEPS_W-1:0] steps);
      return CNT_W'(steps) * CNT_W'(STEP_CYC);
   endfunction : cyc

   function automatic logic [HW-1:0] bandOf(input trq_hyst_t h);
      logic [31:0] b;
      b = 32'(h.absVal);
      if (!h.manual) begin
         b = 32'(AUTO_BAND);
      end else if (h.rel && h.pct) begin
         b = (32'(h.pctVal) * FULL_CODES) / PCT_FULL;
      end else if (h.rel) begin
         b = (32'(h.divVal) * CODES_PER_DIV) / DIV_FULL;
      end
      return b[HW-1:0];
   endfunction : bandOf

   function automatic logic regHit(input logic [7:0] a);
      return a[1:0] == 2'b00 && (a <= OFF_TCOUNT || (a[7:4] >= GRP_HCFG && a[7:4] <= GRP_HEFF));
   endfunction : regHit

   // derived holdoff figures
   wire [SCL_W+STEPS_W-1:0] autoProd = autoScl_r * hScale_r;
   wire [SCL_W+STEPS_W-1:0] autoQ = autoProd / (SCL_W + STEPS_W)'(SCL_ONE);
   wire [STEPS_W-1:0] autoSteps = STEPS_W'(clampU(autoQ[31:0], 32'h0000_0001,
      32'(HOLD_MAX_STEPS)));
   wire [31:0] rndVal;
   wire [STEPS_W-1:0] rndSpan = (rndMax_r >= rndMin_r) ? rndMax_r - rndMin_r : '0;
   wire [STEPS_W+16:0] rndProd = rndVal[15:0] * (17'(rndSpan) + 17'h0_0001);
   wire [STEPS_W-1:0] rndPick = rndMin_r + rndProd[31:16];
   wire [1:0] pinLvl;
   wire hoBlocked = ctrl_r.src >= SRC_EXT || ctrl_r.seq;

   function automatic logic [31:0] regRead(input logic [7:0] a);
      logic [31:0] d;
      trq_hyst_t h;
      h = hyst_r[a[3:2]];
      d = '0;
      case (a)
         OFF_CTRL: d = 32'(ctrl_r);
         OFF_HTIME: d = 32'(hoTime_r);
         OFF_HEVT: d = 32'(hoEvents_r);
         OFF_RMIN: d = 32'(rndMin_r);
         OFF_RMAX: d = 32'(rndMax_r);
         OFF_ASCL: d = 32'(autoScl_r);
         OFF_HSCALE: d = 32'(hScale_r);
         OFF_ATIME: d = 32'(autoSteps);
         OFF_HFCUT: d = 32'(hfCut_r);
         OFF_STAT: d = {26'h000_0000, trigKind, hoBlocked, state_r == ST_HOLD,
            state_r == ST_ARMED};
         OFF_TCOUNT: d = trigCount_r;
         default: begin
            case (a[7:4])
               GRP_HCFG: d = {7'h00, h.divVal, 2'b00, h.pctVal, 5'h00, h.pct, h.rel, h.manual};
               GRP_HABS: d = 32'(h.absVal);
               GRP_HLVL: d = 32'(h.level);
               GRP_HEFF: d = 32'(bandOf(h));
               default: d = '0;
            endcase
         end
      endcase
      return d;
   endfunction : regRead

   // axi write path: address and data latch independently
   wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire wrOk = doWrite && regHit(awAddr_r);
   wire [31:0] strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   wire [31:0] wWord = (regRead(awAddr_r) & ~strbMask) | (wData_r & strbMask);
   wire ctrlWr = wrOk && awAddr_r == OFF_CTRL;
   wire [1:0] wCh = awAddr_r[3:2];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= regHit(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read path: one beat, data taken at the address edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata <= regHit(s_axi_araddr) ? regRead(s_axi_araddr) : '0;
         s_axi_rresp <= regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // settings; out-of-range values are clamped, not rejected
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         hoTime_r <= HTIME_RST;
         hoEvents_r <= EVT_RST;
         rndMin_r <= HTIME_RST;
         rndMax_r <= RMAX_RST;
         autoScl_r <= SCL_RST;
         hScale_r <= HSCALE_RST;
         hfCut_r <= CUT_RST;
         hyst_r <= '0;
         forceReq_r <= 1'b0;
      end else begin
         forceReq_r <= ctrlWr && wWord[CTRL_FORCE_BIT];
         if (wrOk) begin
            case (awAddr_r)
               OFF_CTRL: ctrl_r <= trq_ctrl_t'(wWord[CTRL_W-1:0]);
               OFF_HTIME: hoTime_r <= STEPS_W'(clampU(wWord, 32'h0000_0001,
                  32'(HOLD_MAX_STEPS)));
               OFF_HEVT: hoEvents_r <= EVT_W'(clampU(wWord, 32'h0000_0001, 32'(EVT_MAX)));
               OFF_RMIN: rndMin_r <= STEPS_W'(clampU(wWord, 32'h0000_0001, 32'(RND_MIN_MAX)));
               OFF_RMAX: rndMax_r <= STEPS_W'(clampU(wWord, 32'h0000_0001,
                  32'(HOLD_MAX_STEPS)));
               OFF_ASCL: autoScl_r <= SCL_W'(clampU(wWord, 32'h0000_0001, 32'(SCL_MAX)));
               OFF_HSCALE: hScale_r <= STEPS_W'(clampU(wWord, 32'h0000_0001, 32'h0000_FFFF));
               OFF_HFCUT: hfCut_r <= CUT_W'(clampU(wWord, 32'h0000_0001, 32'(CUT_MAX)));
               default: begin
                  case (awAddr_r[7:4])
                     GRP_HCFG: begin
                        hyst_r[wCh].manual <= wWord[0];
                        hyst_r[wCh].rel <= wWord[1];
                        hyst_r[wCh].pct <= wWord[2];
                        hyst_r[wCh].pctVal <= 6'(clampU(32'(wWord[13:8]), '0, 32'(PCT_MAX)));
                        hyst_r[wCh].divVal <= 9'(clampU(32'(wWord[24:16]), '0, 32'(DIV_MAX)));
                     end
                     GRP_HABS: hyst_r[wCh].absVal <= wWord[SMP_W-1:0];
                     GRP_HLVL: hyst_r[wCh].level <= wWord[SMP_W-1:0];
                     default: ;
                  endcase
               end
            endcase
         end
      end
   end

   // trigger-path filter on the selected channel
   wire [1:0] srcCh = ctrl_r.src[1:0];
   wire signed [SMP_W-1:0] xs = chanSample[srcCh];
   wire signed [ACC_W-1:0] xe = ACC_W'(xs) <<< FRAC;
   wire [4:0] fShift = (ctrl_r.filt == FM_LF) ? LF_SHIFT : cutShift(hfCut_r);
   wire signed [ACC_W-1:0] accNxt = acc_r + ((xe - acc_r) >>> fShift);
   wire signed [HW-1:0] avg = HW'(acc_r >>> FRAC);
   wire signed [HW-1:0] filtNxt = (ctrl_r.filt == FM_LF) ? HW'(xs) - avg :
      (ctrl_r.filt == FM_HF) ? avg : HW'(xs);

   // schmitt qualifier: re-arm only below the band, fire at the level
   wire signed [HW-1:0] lvl = HW'($signed(hyst_r[srcCh].level));
   wire signed [HW-1:0] lowEdge = lvl - $signed(bandOf(hyst_r[srcCh]));
   wire chanEv = bandArmed_r && filt_r >= lvl;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= '0;
         filt_r <= '0;
         bandArmed_r <= 1'b0;
         pinPrev_r <= '0;
      end else begin
         acc_r <= accNxt;
         filt_r <= filtNxt;
         bandArmed_r <= chanEv ? 1'b0 : (bandArmed_r || filt_r <= lowEdge);
         pinPrev_r <= pinLvl;
      end
   end

   trq_sync #(.W(2)) uPins (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pinIn({serialTrigPin, extTrigPin}),
      .level(pinLvl)
   );

   wire [1:0] pinEv = pinLvl & ~pinPrev_r;
   wire srcEv = (ctrl_r.src == SRC_EXT) ? pinEv[0] : (ctrl_r.src == SRC_SERIAL) ? pinEv[1] :
      (ctrl_r.src < SRC_EXT) ? chanEv : 1'b0;

   // acceptance and holdoff
   wire hoActive = ctrl_r.ho != HO_OFF && !hoBlocked;
   wire stArmed = state_r == ST_ARMED;
   wire stHold = state_r == ST_HOLD;
   wire realAcc = stArmed && srcEv && ctrl_r.mode != TM_FREE;
   wire selfAcc = stArmed && ctrl_r.mode != TM_NORM && selfCnt_r == '0;
   wire accept = realAcc || selfAcc || forceReq_r;
   wire trq_kind_t kindNxt = realAcc ? K_REAL : forceReq_r ? K_FORCE :
      (ctrl_r.mode == TM_FREE) ? K_FREE : K_AUTO;
   wire [CNT_W-1:0] holdLoad = (ctrl_r.ho == HO_EVENTS) ? CNT_W'(hoEvents_r) - 1'b1 :
      (ctrl_r.ho == HO_RANDOM) ? cyc(rndPick) :
      (ctrl_r.ho == HO_AUTO) ? cyc(autoSteps) : cyc(hoTime_r);
   wire [CNT_W-1:0] selfLoad = (ctrl_r.mode == TM_FREE) ? CNT_W'(FREE_CYC) :
      cyc(hScale_r) * CNT_W'(TO_DIVS);

   always_comb begin
      state_nxt = state_r;
      hoCnt_nxt = hoCnt_r;
      case (state_r)
         ST_ARMED, ST_HOLD: begin
            if (accept && hoActive) begin
               hoCnt_nxt = holdLoad;
               state_nxt = (holdLoad == '0) ? ST_ARMED : ST_HOLD;
            end else if (accept || !hoActive) begin
               state_nxt = ST_ARMED;
            end else if (stHold && ctrl_r.ho == HO_EVENTS) begin
               hoCnt_nxt = srcEv ? hoCnt_r - 1'b1 : hoCnt_r;
               state_nxt = (srcEv && hoCnt_r <= 1) ? ST_ARMED : ST_HOLD;
            end else if (stHold) begin
               hoCnt_nxt = hoCnt_r - 1'b1;
               state_nxt = (hoCnt_r <= 1) ? ST_ARMED : ST_HOLD;
            end
         end
         default: state_nxt = ST_ARMED;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_ARMED;
         hoCnt_r <= '0;
         selfCnt_r <= '0;
         trigPulse <= 1'b0;
         trigKind <= K_NONE;
         holdoffBusy <= 1'b0;
         trigCount_r <= '0;
      end else begin
         state_r <= state_nxt;
         hoCnt_r <= hoCnt_nxt;
         // timeout restarts on every accepted trigger and on a mode write
         selfCnt_r <= (accept || ctrlWr) ? selfLoad - 1'b1 : (selfCnt_r - (selfCnt_r != '0));
         trigPulse <= accept;
         trigKind <= accept ? kindNxt : trigKind;
         holdoffBusy <= state_nxt == ST_HOLD;
         trigCount_r <= trigCount_r + 32'(accept);
      end
   end

   trq_lfsr uRand (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .advance(accept),
      .value(rndVal)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence sRealInAuto;
      stArmed && ctrl_r.mode == TM_AUTO && srcEv;
   endsequence
   sequence sHoldAccept(trq_hmode_t m);
      accept && hoActive && ctrl_r.ho == m;
   endsequence

   a_auto_real_wins: assert property (sRealInAuto |=> trigPulse && trigKind == K_REAL)
      else $error("real trigger did not win in auto mode");
   a_norm_no_self: assert property (
      ctrl_r.mode == TM_NORM && !forceReq_r && !(srcEv && stArmed) |=> !trigPulse)
      else $error("normal mode triggered without an event");
   a_free_no_real: assert property (ctrl_r.mode == TM_FREE && accept && !forceReq_r |=>
      trigKind == K_FREE) else $error("free-run accepted a real trigger");
   a_force_fires: assert property (forceReq_r |=> trigPulse && holdoffBusy ==
      ($past(hoActive) && $past(holdLoad) != '0)) else $error("force did not trigger at once");
   a_hold_blocks: assert property (stHold && !forceReq_r |=> !trigPulse)
      else $error("trigger passed during holdoff");
   a_hold_bypass: assert property (hoBlocked |=> stArmed && !holdoffBusy)
      else $error("holdoff applied to a blocked source");
   a_time_load: assert property (sHoldAccept(HO_TIME) |=> hoCnt_r == cyc($past(hoTime_r)))
      else $error("time holdoff loaded wrong count");
   a_event_release: assert property (
      stHold && ctrl_r.ho == HO_EVENTS && srcEv && hoCnt_r == 1 && !forceReq_r |=> stArmed)
      else $error("event holdoff did not release");
   a_rand_bounds: assert property (sHoldAccept(HO_RANDOM) |=>
      hoCnt_r >= cyc($past(rndMin_r)) && hoCnt_r <= cyc($past(rndMin_r + rndSpan)))
      else $error("random holdoff out of range");
   a_auto_load: assert property (sHoldAccept(HO_AUTO) |=> hoCnt_r == cyc($past(autoSteps)))
      else $error("auto holdoff loaded wrong count");
endmodule : trq_core

// File: core/trq_lfsr.sv
`timescale 1ns/100ps
module trq_lfsr (
   // clock and reset
   input logic sys_clk,
   input logic rst_n,
   // step and value
   input logic advance,
   output logic [31:0] value
);
   // maximal-length galois taps; never seeded to zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= 32'hACE1_1357;
      end else if (advance) begin
         value <= (value >> 1) ^ (value[0] ? 32'h8020_0003 : 32'h0000_0000);
      end
   end
endmodule : trq_lfsr

// File: core/trq_pkg.sv
package trq_pkg;
   // base timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLK_KHZ = 125_000;
   localparam int HOLD_STEP_NS = 200_000;
   localparam int STEP_CYC_DEF = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FREE_NS = 800;
   localparam int FREE_CYC = (FREE_NS / CLK_PERIOD_NS > 0) ? FREE_NS / CLK_PERIOD_NS : 1;
   localparam int TO_DIVS = 10;
   localparam int LF_CUT_KHZ = 50;
   localparam int OMEGA_KHZ = CLK_KHZ * 159 / 1000;
   // widths
   localparam int NCH = 4;
   localparam int SMP_W = 12;
   localparam int HW = 16;
   localparam int CNT_W = 40;
   localparam int STEPS_W = 16;
   localparam int EVT_W = 31;
   localparam int SCL_W = 20;
   localparam int CUT_W = 19;
   localparam int ACC_W = 28;
   localparam int FRAC = 12;
   localparam int CTRL_W = 11;
   localparam int CTRL_FORCE_BIT = 31;
   // limits and reset values
   localparam logic [STEPS_W-1:0] HOLD_MAX_STEPS = 16'hC350;
   localparam logic [STEPS_W-1:0] RND_MIN_MAX = 16'h61A8;
   localparam logic [STEPS_W-1:0] HTIME_RST = 16'h0005;
   localparam logic [STEPS_W-1:0] RMAX_RST = 16'h000A;
   localparam logic [STEPS_W-1:0] HSCALE_RST = 16'h0005;
   localparam logic [EVT_W-1:0] EVT_MAX = 31'h7FFF_FFFF;
   localparam logic [EVT_W-1:0] EVT_RST = 31'h0000_0001;
   localparam logic [SCL_W-1:0] SCL_MAX = 20'hF_4240;
   localparam logic [SCL_W-1:0] SCL_RST = 20'h0_01F4;
   localparam logic [SCL_W-1:0] SCL_ONE = 20'h0_03E8;
   localparam logic [CUT_W-1:0] CUT_MAX = 19'h7_A120;
   localparam logic [CUT_W-1:0] CUT_RST = 19'h0_03E8;
   localparam logic [5:0] PCT_MAX = 6'h32;
   localparam logic [8:0] DIV_MAX = 9'h1F4;
   localparam int PCT_FULL = 100;
   localparam int DIV_FULL = 100;
   localparam int CODES_PER_DIV = 512;
   localparam int FULL_CODES = 4096;
   localparam logic [SMP_W-1:0] AUTO_BAND = 12'h004;
   // register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_HTIME = 8'h04;
   localparam logic [7:0] OFF_HEVT = 8'h08;
   localparam logic [7:0] OFF_RMIN = 8'h0C;
   localparam logic [7:0] OFF_RMAX = 8'h10;
   localparam logic [7:0] OFF_ASCL = 8'h14;
   localparam logic [7:0] OFF_HSCALE = 8'h18;
   localparam logic [7:0] OFF_ATIME = 8'h1C;
   localparam logic [7:0] OFF_HFCUT = 8'h20;
   localparam logic [7:0] OFF_STAT = 8'h24;
   localparam logic [7:0] OFF_TCOUNT = 8'h28;
   localparam logic [3:0] GRP_HCFG = 4'h3;
   localparam logic [3:0] GRP_HABS = 4'h4;
   localparam logic [3:0] GRP_HLVL = 4'h5;
   localparam logic [3:0] GRP_HEFF = 4'h6;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [2:0] SRC_EXT = 3'h4;
   localparam logic [2:0] SRC_SERIAL = 3'h5;
   // types
   typedef enum logic [1:0] {TM_AUTO = 2'h0, TM_NORM = 2'h1, TM_FREE = 2'h2} trq_tmode_t;
   typedef enum logic [2:0] {
      HO_OFF = 3'h0, HO_TIME = 3'h1, HO_EVENTS = 3'h2, HO_RANDOM = 3'h3, HO_AUTO = 3'h4
   } trq_hmode_t;
   typedef enum logic [1:0] {FM_OFF = 2'h0, FM_LF = 2'h1, FM_HF = 2'h2} trq_filt_t;
   typedef enum logic [2:0] {
      K_NONE = 3'h0, K_REAL = 3'h1, K_AUTO = 3'h2, K_FREE = 3'h3, K_FORCE = 3'h4
   } trq_kind_t;
   typedef enum logic [1:0] {ST_ARMED = 2'b01, ST_HOLD = 2'b10} trq_state_t;
   typedef struct packed {
      logic seq;
      logic [2:0] src;
      trq_filt_t filt;
      trq_hmode_t ho;
      trq_tmode_t mode;
   } trq_ctrl_t;
   typedef struct packed {
      logic [8:0] divVal;
      logic [5:0] pctVal;
      logic [SMP_W-1:0] absVal;
      logic [SMP_W-1:0] level;
      logic pct;
      logic rel;
      logic manual;
   } trq_hyst_t;
   typedef logic [NCH-1:0][SMP_W-1:0] trq_smp_t;
   localparam trq_ctrl_t CTRL_RST = '{1'b0, 3'h0, FM_OFF, HO_OFF, TM_AUTO};

   // first-order section shift whose corner lies at or above the cutoff
   function automatic logic [4:0] cutShift(input logic [CUT_W-1:0] khz);
      logic [4:0] s;
      s = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if ((32'(khz) << (i + 1)) <= OMEGA_KHZ) begin
            s = 5'(i + 1);
         end
      end
      return s;
   endfunction : cutShift

   localparam logic [4:0] LF_SHIFT = cutShift(19'(LF_CUT_KHZ));
endpackage : trq_pkg

// File: core/trq_sync.sv
`timescale 1ns/100ps
module trq_sync #(
   parameter int W = 2
) (
   // clock and reset
   input logic sys_clk,
   input logic rst_n,
   // pins and settled levels
   input logic [W-1:0] pinIn,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_r, s2_r, s3_r;

   // a change counts only once the last two stages agree
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         level <= '0;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         level <= (s2_r & s3_r) | (level & (s2_r | s3_r));
      end
   end
endmodule : trq_sync

// File: tb/trigger_mode_holdoff_qualifier_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nMismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module trigger_mode_holdoff_qualifier_tb_top;
   import trq_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, halfPer = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, extOn = 0, extPin = 0;
   logic awready, wready, bvalid, arready, rvalid, trigPulse, holdoffBusy;
   logic [1:0] bresp, rresp, rsp;
   trq_kind_t trigKind;
   trq_smp_t chanSample;
   trq_kind_t kq[$];
   int pq[$];
   int nMismatch = 0, checksDone = 0, cyc = 0;
   logic [7:0] ra[8] = '{OFF_CTRL, OFF_HTIME, OFF_HEVT, OFF_ASCL, OFF_HSCALE, OFF_ATIME,
      OFF_HFCUT, 8'h60};
   int rv[8] = '{0, 5, 1, 500, 5, 2, 1000, 4};
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (extOn && (cyc % 20) == 0) extPin <= ~extPin;
      if (trigPulse === 1'b1) begin
         pq.push_back(cyc);
         kq.push_back(trigKind);
      end
   end
   trq_chan_model u_chan (.sys_clk(sys_clk), .halfPer(halfPer), .chanSample(chanSample));
   trq_core #(.STEP_CYC(4)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .chanSample(chanSample), .extTrigPin(extPin), .serialTrigPin(extPin),
      .trigPulse(trigPulse), .trigKind(trigKind), .holdoffBusy(holdoffBusy));
   task automatic conclude(input bit hang);
      if (hang) nMismatch++;
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 50) conclude(1'b1);
      rsp = bresp;
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 50) conclude(1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask : rdr
   // skip the settling after a change, then judge spacing and kind of three pulses
   task automatic meas(input int sp, input trq_kind_t k);
      int i;
      repeat (20) @(posedge sys_clk);
      pq.delete();
      kq.delete();
      for (i = 0; i < 3000 && pq.size() < 4; i++) @(posedge sys_clk);
      if (pq.size() < 4) conclude(1'b1);
      for (i = 1; i < 4; i++) begin
         `CHK(pq[i] - pq[i-1], sp)
         `CHK(kq[i], k)
      end
   endtask : meas
   // time one holdoff window by the busy flag that follows a pulse
   task automatic busy(input int e);
      int i, c;
      c = 0;
      for (i = 0; i < 3000 && trigPulse !== 1'b1; i++) @(posedge sys_clk);
      if (i == 3000) conclude(1'b1);
      for (i = 0; i < 3000 && holdoffBusy === 1'b1; i++) begin
         c++;
         @(posedge sys_clk);
      end
      `CHK(c, e)
   endtask : busy
   initial begin
      int n;
      void'($urandom(32'hb232));
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      `CHK(kq[0], K_AUTO)
      for (n = 0; n < 8; n++) begin
         rdr(ra[n]);
         `CHK(rd, 32'(rv[n]))
      end
      wr(OFF_ATIME, 32'h0000_0007);
      rdr(OFF_ATIME);
      `CHK(rd, 32'h0000_0002)
      wr(8'hFC, 32'h0000_0000);
      `CHK(rsp, RESP_SLVERR)
      rdr(8'hFC);
      `CHK(rsp, RESP_SLVERR)
      wr(OFF_ASCL, 32'h0000_03E8);
      rdr(OFF_ATIME);
      `CHK(rd, 32'h0000_0005)
      wr(OFF_CTRL, 32'h0000_0001);
      pq.delete();
      kq.delete();
      // longer than the auto timeout, so a stray self trigger would show
      repeat (400) @(posedge sys_clk);
      `CHK(pq.size(), 0)
      wr(OFF_CTRL, 32'h8000_0001);
      repeat (5) @(posedge sys_clk);
      `CHK(kq[0], K_FORCE)
      halfPer <= 8'h03;
      meas(6, K_REAL);
      wr(OFF_HTIME, 32'h0000_0002);
      wr(OFF_CTRL, 32'h0000_0005);
      meas(12, K_REAL);
      busy(2 * 4);
      wr(OFF_CTRL, 32'h0000_0011);
      meas(24, K_REAL);
      n = 1 + $urandom_range(3);
      wr(OFF_RMIN, 32'(n));
      wr(OFF_RMAX, 32'(n));
      wr(OFF_CTRL, 32'h0000_000D);
      meas(6 * (4 * n / 6 + 1), K_REAL);
      wr(OFF_CTRL, 32'h0000_0405);
      meas(6, K_REAL);
      n = 2 + $urandom_range(2);
      wr(OFF_HEVT, 32'(n));
      wr(OFF_CTRL, 32'h0000_0009);
      meas(6 * n, K_REAL);
      wr(OFF_CTRL, 32'h0000_0021);
      meas(6, K_REAL);
      wr(OFF_CTRL, 32'h0000_0000);
      meas(6, K_REAL);
      wr(OFF_CTRL, 32'h0000_0002);
      meas(FREE_CYC, K_FREE);
      halfPer <= 8'h00;
      extOn <= 1'b1;
      wr(OFF_HTIME, 32'h0000_0032);
      wr(OFF_CTRL, 32'h0000_0205);
      meas(40, K_REAL);
      wr(OFF_CTRL, 32'h0000_0285);
      meas(40, K_REAL);
      halfPer <= 8'h03;
      wr(8'h30, 32'h0000_0A06);
      rdr(8'h60);
      `CHK(rd, 32'(AUTO_BAND))
      wr(8'h30, 32'h0000_0A07);
      rdr(8'h60);
      `CHK(rd, 32'(10 * FULL_CODES / PCT_FULL))
      wr(8'h30, 32'h0096_0003);
      rdr(8'h60);
      `CHK(rd, 32'(150 * CODES_PER_DIV / DIV_FULL))
      wr(OFF_CTRL, 32'h0000_0001);
      repeat (20) @(posedge sys_clk);
      pq.delete();
      // a band wider than the swing must keep the qualifier disarmed
      repeat (100) @(posedge sys_clk);
      `CHK(pq.size(), 0)
      conclude(1'b0);
   end
endmodule : trigger_mode_holdoff_qualifier_tb_top

// File: tb/trq_chan_model.sv
`timescale 1ns/100ps
module trq_chan_model
   import trq_pkg::*;
(
   // clock and pattern
   input wire logic sys_clk,
   input wire logic [7:0] halfPer,
   // comparator samples
   output trq_pkg::trq_smp_t chanSample
);
   logic [7:0] cnt_r = 8'h00;
   logic hi_r = 1'b0;
   always @(posedge sys_clk) begin
      if (cnt_r + 8'h01 >= halfPer) begin
         cnt_r <= 8'h00;
         hi_r <= (halfPer != 8'h00) & ~hi_r;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
      // idle channels carry noise so only the selected one may fire
      chanSample <= {36'($urandom), hi_r ? 12'h064 : 12'hF9C};
   end
endmodule : trq_chan_model
